// >>> gof_pkg.sv
package gof_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int GOF_PINS = 4;
	localparam int GOF_FN_W = 9;
	localparam int GOF_RAW_W = 28;
	localparam int GOF_IDX_W = 10;

	// ------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [9:0] GOF_IDX_FN0 = 10'h100;
	localparam logic [9:0] GOF_IDX_SYNC_CTL = 10'h149;
	localparam logic [9:0] GOF_IDX_ASYNC_CTL = 10'h14A;
	localparam logic [9:0] GOF_IDX_RAW = 10'h150;
	localparam logic [9:0] GOF_IDX_LATCH = 10'h151;

	// ------------------------------------------------------------
	// clock output control fields
	// ------------------------------------------------------------
	localparam int GOF_ENA_BIT = 15;
	localparam int GOF_DIV_LSB = 3;
	localparam int GOF_SEL_LSB = 0;
	localparam logic [15:0] GOF_CTL_MASK = 16'h80FF;
	localparam logic [15:0] GOF_CTL_RESET = 16'h0000;
	localparam logic [8:0] GOF_FN_RESET = 9'h000;

	// ------------------------------------------------------------
	// status vector layout
	// ------------------------------------------------------------
	localparam int GOF_B_FLL = 0;
	localparam int GOF_B_RATE_CONVERTER = 3;
	localparam int GOF_B_WARN = 7;
	localparam int GOF_B_SHUT = 8;
	localparam int GOF_B_SHORT = 9;
	localparam int GOF_B_SPKDN = 11;
	localparam int GOF_B_TMR = 12;
	localparam int GOF_B_EVL = 20;
	localparam logic [27:0] GOF_BOTH_EDGE = 28'h000007F;

	// ------------------------------------------------------------
	// pin function codes
	// ------------------------------------------------------------
	localparam logic [8:0] GOF_FN_SYNC_CLK = 9'h040;
	localparam logic [8:0] GOF_FN_ASYNC_CLK = 9'h041;
	localparam logic [8:0] GOF_FN_PWM1 = 9'h048;
	localparam logic [8:0] GOF_FN_PWM2 = 9'h049;
	localparam logic [8:0] GOF_FN_SPDIF = 9'h04C;
	localparam logic [8:0] GOF_FN_ASRC0 = 9'h088;
	localparam logic [8:0] GOF_FN_ASRC3 = 9'h08B;
	localparam logic [8:0] GOF_FN_WARN = 9'h0B6;
	localparam logic [8:0] GOF_FN_SHUT = 9'h0B7;
	localparam logic [8:0] GOF_FN_SHORT0 = 9'h0E0;
	localparam logic [8:0] GOF_FN_SHORT1 = 9'h0E1;
	localparam logic [8:0] GOF_FN_SPKDN = 9'h0E2;
	localparam logic [8:0] GOF_FN_TMR0 = 9'h140;
	localparam logic [8:0] GOF_FN_TMR7 = 9'h147;
	localparam logic [8:0] GOF_FN_EVL0 = 9'h150;
	localparam logic [8:0] GOF_FN_EVL7 = 9'h157;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] pre;
		logic [3:0] cnt;
		logic out;
	} gof_div_t;

	typedef struct packed {
		logic [3:0][8:0] fn;
		logic [15:0] sync_ctl;
		logic [15:0] async_ctl;
		logic [27:0] s1;
		logic [27:0] s2;
		logic [27:0] prev;
		logic [27:0] latch;
		logic [2:0] aclk_sy;
		gof_div_t sdiv;
		gof_div_t adiv;
		logic [3:0] pins;
		logic spk_disable;
		logic spk_status;
		logic wr_pend;
		logic [9:0] wr_idx;
		logic [31:0] rdata;
	} gof_state_t;

endpackage

// >>> gof_pin_mux.sv
// Behaviour
// - lock edges both ways latch interrupt bits
// - code 040h drives sync divided clock
// - code 041h drives async divided clock
// - async control bit 15 enables output
// - async divider bits 7:3, even ratios
// - async prescale select bits 2:0 (3: divide by 1, 2: by 2, 1: by 4, others: by 8)
// - codes 048h/049h route pwm outputs
// - code 04Ch routes spdif output
// - rate-converter lock pins, both-edge interrupts
// - thermal, short and speaker status codes
// - overheat shutdown or short disables speaker
// - speaker status only after shutdown completes
// - protection flags latch interrupt on rising
// - codes 140h-147h route timer pulses
// - timer final count latches interrupt
// - timers count either direction and mode
// - codes 150h-157h route fifo not empty
// - fifo not empty latches interrupt
// - latched bits clear on write one
module gof_pin_mux
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic async_src_clk,
	input wire logic [2:0] fll_lock,
	input wire logic [3:0] rate_converter_lock,
	input wire logic overheat_warn,
	input wire logic overheat_shut,
	input wire logic [1:0] spk_short,
	input wire logic spk_shutdown_done,
	input wire logic [7:0] timer_final,
	input wire logic [7:0] evlog_not_empty,
	input wire logic [1:0] pwm_out,
	input wire logic spdif_out,
	output logic [gof_pkg::GOF_PINS-1:0] pin_out,
	output logic spk_disable,
	output logic irq_out
);
	import gof_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic gof_div_t gof_div_step(input gof_div_t d, input logic tick,
		input logic [15:0] ctl);
		gof_div_t n;
		logic [2:0] mask;
		logic [3:0] half;
		n = d;
		mask = 3'h0;
		half = ctl[GOF_DIV_LSB+4:GOF_DIV_LSB+1];
		if (half == 4'h0)
			half = 4'h1;
		case (ctl[GOF_SEL_LSB+2:GOF_SEL_LSB])
			3'h3: mask = 3'h0;
			3'h2: mask = 3'h1;
			3'h1: mask = 3'h3;
			default: mask = 3'h7;
		endcase
		if (!ctl[GOF_ENA_BIT])
		begin
			n = '0;
		end
		else if (tick)
		begin
			n.pre = d.pre + 3'h1;
			if ((d.pre & mask) == mask)
			begin
				n.pre = 3'h0;
				if (d.cnt >= half - 4'h1)
				begin
					n.cnt = 4'h0;
					n.out = ~d.out;
				end
				else
					n.cnt = d.cnt + 4'h1;
			end
		end
		return n;
	endfunction

	function automatic logic gof_route(input logic [8:0] code, input logic [27:0] raw,
		input logic sclk, input logic aclk, input logic [1:0] pwm, input logic spdif);
		logic r;
		r = 1'b0;
		if (code == GOF_FN_SYNC_CLK)
			r = sclk;
		else if (code == GOF_FN_ASYNC_CLK)
			r = aclk;
		else if (code == GOF_FN_PWM1)
			r = pwm[0];
		else if (code == GOF_FN_PWM2)
			r = pwm[1];
		else if (code == GOF_FN_SPDIF)
			r = spdif;
		else if (code >= GOF_FN_ASRC0 && code <= GOF_FN_ASRC3)
			r = raw[GOF_B_RATE_CONVERTER + int'(code[1:0])];
		else if (code == GOF_FN_WARN)
			r = raw[GOF_B_WARN];
		else if (code == GOF_FN_SHUT)
			r = raw[GOF_B_SHUT];
		else if (code == GOF_FN_SHORT0 || code == GOF_FN_SHORT1)
			r = raw[GOF_B_SHORT + int'(code[0])];
		else if (code == GOF_FN_SPKDN)
			r = raw[GOF_B_SPKDN];
		else if (code >= GOF_FN_TMR0 && code <= GOF_FN_TMR7)
			r = raw[GOF_B_TMR + int'(code[2:0])];
		else if (code >= GOF_FN_EVL0 && code <= GOF_FN_EVL7)
			r = raw[GOF_B_EVL + int'(code[2:0])];
		return r;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	gof_state_t st_reg;
	gof_state_t st_next;
	logic [27:0] pin_in;
	logic [27:0] raw;
	logic [27:0] edges;
	logic [27:0] clr;
	logic addr_ok;
	logic [9:0] a_idx;

	// timer pulses arrive whatever the count direction or mode
	assign pin_in = {evlog_not_empty, timer_final, spk_shutdown_done, spk_short,
		overheat_shut, overheat_warn, rate_converter_lock, fll_lock};
	assign addr_ok = hsel && htrans[1] && hready;
	assign a_idx = haddr[11:2];

	always_comb
	begin
		raw = st_reg.s2;
		raw[GOF_B_SPKDN] = st_reg.spk_status;
		edges = (raw ^ st_reg.prev) & GOF_BOTH_EDGE;
		edges = edges | (raw & ~st_reg.prev & ~GOF_BOTH_EDGE);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		clr = '0;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.prev = raw;
		st_next.aclk_sy = {st_reg.aclk_sy[1:0], async_src_clk};
		st_next.spk_disable = st_reg.s2[GOF_B_SHUT] | (|st_reg.s2[GOF_B_SHORT+1:GOF_B_SHORT]);
		st_next.spk_status = st_reg.s2[GOF_B_SPKDN] & st_reg.spk_disable;
		if (st_reg.wr_pend)
		begin
			for (int i = 0; i < GOF_PINS; i++)
			begin
				if (st_reg.wr_idx == GOF_IDX_FN0 + 10'(i))
					st_next.fn[i] = hwdata[8:0];
			end
			if (st_reg.wr_idx == GOF_IDX_SYNC_CTL)
				st_next.sync_ctl = hwdata[15:0] & GOF_CTL_MASK;
			if (st_reg.wr_idx == GOF_IDX_ASYNC_CTL)
				st_next.async_ctl = hwdata[15:0] & GOF_CTL_MASK;
			if (st_reg.wr_idx == GOF_IDX_LATCH)
				clr = hwdata[27:0];
		end
		st_next.latch = (st_reg.latch & ~clr) | edges;
		st_next.sdiv = gof_div_step(st_reg.sdiv, 1'b1, st_reg.sync_ctl);
		st_next.adiv = gof_div_step(st_reg.adiv, st_reg.aclk_sy[1] & ~st_reg.aclk_sy[2],
			st_reg.async_ctl);
		for (int i = 0; i < GOF_PINS; i++)
		begin
			st_next.pins[i] = gof_route(st_reg.fn[i], raw, st_reg.sdiv.out, st_reg.adiv.out,
				pwm_out, spdif_out);
		end
		st_next.wr_pend = addr_ok && hwrite;
		st_next.wr_idx = a_idx;
		st_next.rdata = '0;
		if (addr_ok && !hwrite)
		begin
			for (int i = 0; i < GOF_PINS; i++)
			begin
				if (a_idx == GOF_IDX_FN0 + 10'(i))
					st_next.rdata = {23'h0, st_next.fn[i]};
			end
			case (a_idx)
				GOF_IDX_SYNC_CTL: st_next.rdata = {16'h0, st_next.sync_ctl};
				GOF_IDX_ASYNC_CTL: st_next.rdata = {16'h0, st_next.async_ctl};
				GOF_IDX_RAW: st_next.rdata = {4'h0, raw};
				GOF_IDX_LATCH: st_next.rdata = {4'h0, st_next.latch};
				default: st_next.rdata = st_next.rdata;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			st_reg <= '0;
			st_reg.fn <= {GOF_PINS{GOF_FN_RESET}};
			st_reg.sync_ctl <= GOF_CTL_RESET;
			st_reg.async_ctl <= GOF_CTL_RESET;
		end
		else
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_reg.rdata;
	assign pin_out = st_reg.pins;
	assign spk_disable = st_reg.spk_disable;
	assign irq_out = |st_reg.latch;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_fll_both_edges: assert property (@(posedge sys_clk) disable iff (reset)
		$changed(st_reg.s2[GOF_B_FLL]) |-> ##1 st_reg.latch[GOF_B_FLL])
		else $error("lock edge not latched");

	a_rate_converter_latch_hold: assert property (@(posedge sys_clk) disable iff (reset)
		$changed(st_reg.s2[GOF_B_RATE_CONVERTER]) |-> ##1 st_reg.latch[GOF_B_RATE_CONVERTER] ##1
		(st_reg.latch[GOF_B_RATE_CONVERTER] || $past(st_reg.wr_pend)))
		else $error("rate converter lock edge lost");

	a_irq_holds: assert property (@(posedge sys_clk) disable iff (reset)
		(irq_out && !(st_reg.wr_pend && st_reg.wr_idx == GOF_IDX_LATCH)) |=> irq_out)
		else $error("irq dropped without a clear");

	a_clear_on_one: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.wr_pend && st_reg.wr_idx == GOF_IDX_LATCH && hwdata[GOF_B_TMR]
		&& !edges[GOF_B_TMR]) |=> !st_reg.latch[GOF_B_TMR])
		else $error("write one did not clear");

	a_sync_clk_off: assert property (@(posedge sys_clk) disable iff (reset)
		!st_reg.sync_ctl[GOF_ENA_BIT] |=> !st_reg.sdiv.out)
		else $error("sync clock not low while disabled");

	a_sync_div_two: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.sync_ctl == 16'h8013) [*4] |-> st_reg.sdiv.out != $past(st_reg.sdiv.out))
		else $error("divide by two does not toggle every cycle");

	a_pin_sync_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_SYNC_CLK) |=> pin_out[0] == $past(st_reg.sdiv.out))
		else $error("pin does not carry sync clock");

	a_pin_evlog_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[1] == GOF_FN_EVL0) |=> pin_out[1] == $past(raw[GOF_B_EVL]))
		else $error("pin does not carry fifo status");

	a_spk_protect: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.s2[GOF_B_SHUT] || st_reg.s2[GOF_B_SHORT]) |=> spk_disable)
		else $error("speaker not disabled");

	a_spk_status_late: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(st_reg.spk_status) |-> $past(st_reg.spk_disable) && $past(st_reg.s2[GOF_B_SPKDN]))
		else $error("speaker status before shutdown done");

	a_timer_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(st_reg.s2[GOF_B_TMR]) |=> st_reg.latch[GOF_B_TMR])
		else $error("timer event not latched");

	a_async_ctl_mask: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.wr_pend && st_reg.wr_idx == GOF_IDX_ASYNC_CTL) |=>
		st_reg.async_ctl == ($past(hwdata[15:0]) & GOF_CTL_MASK))
		else $error("async control write wrong");

	a_fll_fall_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(st_reg.s2[GOF_B_FLL]) |=> st_reg.latch[GOF_B_FLL])
		else $error("lock fall not latched");

	a_rate_converter_fall_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(st_reg.s2[GOF_B_RATE_CONVERTER]) |=> st_reg.latch[GOF_B_RATE_CONVERTER])
		else $error("rate converter lock fall not latched");

	a_async_clk_off: assert property (@(posedge sys_clk) disable iff (reset)
		!st_reg.async_ctl[GOF_ENA_BIT] |=> !st_reg.adiv.out)
		else $error("async clock not low while disabled");

	a_pin_async_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_ASYNC_CLK) |=> pin_out[0] == $past(st_reg.adiv.out))
		else $error("pin does not carry async clock");

	a_pin_pwm_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_PWM1) |=> pin_out[0] == $past(pwm_out[0]))
		else $error("pin does not carry first pwm");

	a_pin_pwm2_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_PWM2) |=> pin_out[0] == $past(pwm_out[1]))
		else $error("pin does not carry second pwm");

	a_pin_spdif_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_SPDIF) |=> pin_out[0] == $past(spdif_out))
		else $error("pin does not carry spdif");

	a_pin_rate_converter_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_ASRC0) |=> pin_out[0] == $past(raw[GOF_B_RATE_CONVERTER]))
		else $error("pin does not carry rate converter lock");

	a_pin_warn_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_WARN) |=> pin_out[0] == $past(raw[GOF_B_WARN]))
		else $error("pin does not carry overheat warning");

	a_pin_shut_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_SHUT) |=> pin_out[0] == $past(raw[GOF_B_SHUT]))
		else $error("pin does not carry overheat shutdown");

	a_pin_short_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_SHORT0) |=> pin_out[0] == $past(raw[GOF_B_SHORT]))
		else $error("pin does not carry short status");

	a_pin_spk_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[0] == GOF_FN_SPKDN) |=> pin_out[0] == $past(st_reg.spk_status))
		else $error("pin does not carry speaker status");

	a_pin_timer_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[3] == GOF_FN_TMR0) |=> pin_out[3] == $past(raw[GOF_B_TMR]))
		else $error("pin does not carry timer pulse");

	a_pin_evlog7_route: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.fn[2] == GOF_FN_EVL7) |=> pin_out[2] == $past(raw[GOF_B_EVL+7]))
		else $error("pin does not carry last fifo status");

	a_warn_rise_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(st_reg.s2[GOF_B_WARN]) |=> st_reg.latch[GOF_B_WARN])
		else $error("warning event not latched");

	a_short_rise_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(st_reg.s2[GOF_B_SHORT]) |=> st_reg.latch[GOF_B_SHORT])
		else $error("short event not latched");

	a_spk_rise_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(st_reg.spk_status) |=> st_reg.latch[GOF_B_SPKDN])
		else $error("speaker status event not latched");

	a_evlog_latch: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(st_reg.s2[GOF_B_EVL]) |=> st_reg.latch[GOF_B_EVL])
		else $error("fifo event not latched");

	a_timer_latch_hold: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.latch[GOF_B_TMR] && !(st_reg.wr_pend && st_reg.wr_idx == GOF_IDX_LATCH
		&& hwdata[GOF_B_TMR])) |=> st_reg.latch[GOF_B_TMR])
		else $error("latched bit lost without write one");

	a_spk_short_two: assert property (@(posedge sys_clk) disable iff (reset)
		st_reg.s2[GOF_B_SHORT+1] |=> spk_disable)
		else $error("speaker not disabled on second short");

	a_sync_ctl_mask: assert property (@(posedge sys_clk) disable iff (reset)
		(st_reg.wr_pend && st_reg.wr_idx == GOF_IDX_SYNC_CTL) |=>
		st_reg.sync_ctl == ($past(hwdata[15:0]) & GOF_CTL_MASK))
		else $error("sync control write wrong");

	a_irq_on_event: assert property (@(posedge sys_clk) disable iff (reset)
		(edges != 28'h0) |=> irq_out)
		else $error("event did not raise irq");

endmodule

// >>> gof_pin_rx.sv
module gof_pin_rx
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic pin,
	output int period
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	logic last;
	// ----------------------------------------
	// cycles between rising edges of the pin
	// ----------------------------------------
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			cnt <= 0;
			last <= 1'b0;
			period <= 0;
		end
		else
		begin
			last <= pin;
			cnt <= (pin && !last) ? 1 : cnt + 1;
			if (pin && !last)
				period <= cnt;
		end
	end
endmodule

// >>> gof_pin_mux_tb.sv
`define CHK(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
		end \
	end
module gof_pin_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import gof_pkg::*;
	logic sys_clk, reset, hsel, hwrite, hreadyout, hresp, async_src_clk, spdif_out;
	logic [31:0] haddr, hwdata, hrdata, obs, exp_v;
	logic [1:0] htrans, pwm_out;
	logic [2:0] hsize, chk_sel, pw;
	logic [27:0] st;
	logic [3:0] pin_out;
	logic spk_disable, irq_out;
	logic [8:0] code;
	logic [31:0] exp_q[$];
	int num_errors, n_checks, seed, period, i;
	gof_pin_mux i_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .async_src_clk(async_src_clk),
		.fll_lock(st[2:0]), .rate_converter_lock(st[6:3]), .overheat_warn(st[7]), .overheat_shut(st[8]),
		.spk_short(st[10:9]), .spk_shutdown_done(st[11]), .timer_final(st[19:12]),
		.evlog_not_empty(st[27:20]), .pwm_out(pwm_out), .spdif_out(spdif_out),
		.pin_out(pin_out), .spk_disable(spk_disable), .irq_out(irq_out));
	gof_pin_rx i_rx (.sys_clk(sys_clk), .reset(reset), .pin(pin_out[0]), .period(period));
	// ----------------------------------------
	// clocks
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		async_src_clk = 1'b0;
		#37;
		// one async tick every four sys_clk cycles
		forever #200 async_src_clk = ~async_src_clk;
	end
	// ----------------------------------------
	// driver tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
		chk_sel <= 3'd0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, idx, 2'b00};
		hwrite <= w;
		if (!w)
			exp_q.push_back(d);
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		chk_sel <= w ? 3'd0 : 3'd1;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
	endtask
	task automatic chk(input logic [2:0] s, input logic [31:0] e);
		exp_q.push_back(e);
		chk_sel <= s;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		chk_sel <= 3'd0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// monitor: oldest note against the output
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (chk_sel != 3'd0)
		begin
			case (chk_sel)
				3'd1: obs = hrdata;
				3'd2: obs = {31'h0, pin_out[0]};
				3'd3: obs = {31'h0, irq_out};
				3'd4: obs = {31'h0, spk_disable};
				3'd6: obs = {29'h0, pin_out[3:1]};
				default: obs = period;
			endcase
			exp_v = exp_q.pop_front();
			`CHK(obs, exp_v)
			if (chk_sel == 3'd1)
				`CHK({30'h0, hresp, hreadyout}, 32'h1)
		end
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		summarize();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed = 84874;
		reset = 1'b1;
		{hsel, hwrite, spdif_out} = 3'b000;
		{haddr, hwdata} = 64'h0;
		{htrans, pwm_out} = 4'h0;
		hsize = 3'b010;
		chk_sel = 3'd0;
		st = 28'h0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		bus(0, GOF_IDX_FN0, 32'h0);
		bus(0, GOF_IDX_ASYNC_CTL, 32'h0);
		bus(0, GOF_IDX_LATCH, 32'h0);
		bus(1, 10'h3FF, 32'hFFFFFFFF);
		bus(0, 10'h3FF, 32'h0);
		bus(1, GOF_IDX_ASYNC_CTL, 32'h0000FFFF);
		bus(0, GOF_IDX_ASYNC_CTL, 32'h000080FF);
		bus(1, GOF_IDX_ASYNC_CTL, 32'h0);
		bus(1, GOF_IDX_FN0 + 10'h1, 32'h150);
		bus(1, GOF_IDX_FN0 + 10'h2, 32'h157);
		bus(1, GOF_IDX_FN0 + 10'h3, 32'h140);
		for (i = 3; i < 28; i++)
		begin
			if (i == 11)
				continue;
			code = i < 7 ? 9'h088 + i - 3 : i < 9 ? 9'h0B6 + i - 7 : i < 11 ? 9'h0E0 + i - 9 :
				i < 20 ? 9'h140 + i - 12 : 9'h150 + i - 20;
			bus(1, GOF_IDX_FN0, {23'h0, code});
			st <= 28'($random(seed)) | (28'h1 << i);
			idle(5);
			chk(2, 1);
			chk(6, {29'h0, st[GOF_B_TMR], st[GOF_B_EVL+7], st[GOF_B_EVL]});
			st <= 28'($random(seed)) & ~(28'h1 << i);
			idle(5);
			chk(2, 0);
		end
		for (i = 0; i < 3; i++)
		begin
			bus(1, GOF_IDX_FN0, i < 2 ? 32'h048 + i : 32'h04C);
			pw = 3'($random(seed));
			pwm_out <= pw[1:0];
			spdif_out <= pw[2];
			idle(3);
			chk(2, {31'h0, pw[i]});
		end
		st <= 28'h0;
		idle(6);
		bus(1, GOF_IDX_LATCH, 32'hFFFFFFFF);
		bus(0, GOF_IDX_LATCH, 32'h0);
		chk(3, 0);
		st <= 28'h1;
		idle(5);
		bus(0, GOF_IDX_LATCH, 32'h1);
		chk(3, 1);
		bus(1, GOF_IDX_LATCH, 32'h1);
		st <= 28'h80;
		idle(5);
		bus(0, GOF_IDX_LATCH, 32'h81);
		bus(1, GOF_IDX_LATCH, 32'h81);
		st <= 28'h0;
		idle(5);
		bus(0, GOF_IDX_LATCH, 32'h0);
		bus(1, GOF_IDX_LATCH, 32'h1);
		st <= 28'h1000;
		idle(1);
		st <= 28'h100000;
		idle(5);
		bus(0, GOF_IDX_RAW, 32'h100000);
		bus(0, GOF_IDX_LATCH, 32'h101000);
		st <= 28'h0;
		idle(4);
		bus(1, GOF_IDX_LATCH, 32'hFFFFFFFF);
		chk(3, 0);
		bus(1, GOF_IDX_FN0, 32'h0E2);
		st <= 28'h800;
		idle(5);
		chk(2, 0);
		st <= 28'h900;
		idle(6);
		chk(2, 1);
		chk(4, 1);
		st <= 28'h200;
		idle(5);
		chk(4, 1);
		st <= 28'h0;
		bus(1, GOF_IDX_FN0, 32'h040);
		bus(1, GOF_IDX_SYNC_CTL, 32'h0013);
		bus(1, GOF_IDX_SYNC_CTL, 32'h8013);
		idle(10);
		chk(5, 2);
		bus(1, GOF_IDX_SYNC_CTL, 32'h0023);
		bus(1, GOF_IDX_SYNC_CTL, 32'h8023);
		idle(20);
		chk(5, 4);
		bus(1, GOF_IDX_SYNC_CTL, 32'h0033);
		bus(1, GOF_IDX_SYNC_CTL, 32'h8033);
		idle(20);
		chk(5, 6);
		bus(1, GOF_IDX_SYNC_CTL, 32'h0033);
		idle(3);
		chk(2, 0);
		idle(3);
		chk(2, 0);
		bus(1, GOF_IDX_FN0, 32'h041);
		bus(1, GOF_IDX_ASYNC_CTL, 32'h0013);
		bus(1, GOF_IDX_ASYNC_CTL, 32'h8013);
		idle(40);
		chk(5, 8);
		bus(1, GOF_IDX_ASYNC_CTL, 32'h0013);
		idle(4);
		chk(2, 0);
		idle(2);
		summarize();
	end
endmodule
